/* File: link_margin_pkg.sv */
// Constants, field layout and state codes for the link compliance margin block
//----------------------------------------------------------------------------
// Contract
// - Swing codes 1 to 5 select 900/700/500/300/200 or 500..100 mV.
// - Swing codes 6 and 7 are reserved, no defined margin level.
// - Swing code 0 hands drive level to the per-lane drive registers.
// - Entering Polling.Configuration clears the swing field to zero; a software write in the same cycle wins.
// - New swing reaches the line only at a margin-change state.
// - Modified bit set sends modified compliance pattern in Polling.Compliance.
// - Skip bit set inserts skip ordered sets between compliance patterns.
// - De-emphasis bit picks -6.0 dB when 0, -3.5 dB when 1.
// - De-emphasis bit applies only when compliance was forced by software.
//----------------------------------------------------------------------------
package link_margin_pkg;

    //------------------------------------------------------------------------
    // Register map
    //------------------------------------------------------------------------
    localparam int          ADDR_W             = 12;
    localparam int          DATA_W             = 16;
    localparam logic [11:0] LCTL2_OFFSET       = 12'h070;
    localparam logic [11:0] MARGIN_STAT_OFFSET = 12'h0F0;
    localparam logic [15:0] RDATA_ZERO         = 16'h0000;

    //------------------------------------------------------------------------
    // Field layout of the control register
    //------------------------------------------------------------------------
    localparam int SWING_LSB  = 7;
    localparam int SWING_MSB  = 9;
    localparam int MODPAT_BIT = 10;
    localparam int SKIP_BIT   = 11;
    localparam int DEEMPH_BIT = 12;

    //------------------------------------------------------------------------
    // Field layout of the status register
    //------------------------------------------------------------------------
    localparam int STAT_SWING_LSB = 0;
    localparam int STAT_SWING_MSB = 2;
    localparam int STAT_LANE_BIT  = 3;
    localparam int STAT_RSVD_BIT  = 4;
    localparam int STAT_CMPL_BIT  = 5;
    localparam int STAT_MODP_BIT  = 6;
    localparam int STAT_SKIP_BIT  = 7;
    localparam int STAT_DEEM_BIT  = 8;

    //------------------------------------------------------------------------
    // Reset values and codes
    //------------------------------------------------------------------------
    localparam logic [2:0] SWING_NORMAL   = 3'h0;
    localparam logic [2:0] SWING_RESET    = 3'h0;
    localparam logic       BIT_RESET      = 1'h0;
    localparam logic       DEEMPH_6DB     = 1'h0;
    localparam logic       DEEMPH_3P5DB   = 1'h1;
    localparam logic [7:0] LANE_DRV_RESET = 8'h00;

    //------------------------------------------------------------------------
    // Margin voltages in mV, full swing then low swing
    //------------------------------------------------------------------------
    localparam logic [9:0] MV_NONE   = 10'h000;
    localparam logic [9:0] MV_FULL_1 = 10'd900;
    localparam logic [9:0] MV_FULL_2 = 10'd700;
    localparam logic [9:0] MV_FULL_3 = 10'd500;
    localparam logic [9:0] MV_FULL_4 = 10'd300;
    localparam logic [9:0] MV_FULL_5 = 10'd200;
    localparam logic [9:0] MV_LOW_1  = 10'd500;
    localparam logic [9:0] MV_LOW_2  = 10'd400;
    localparam logic [9:0] MV_LOW_3  = 10'd300;
    localparam logic [9:0] MV_LOW_4  = 10'd200;
    localparam logic [9:0] MV_LOW_5  = 10'd100;

    //------------------------------------------------------------------------
    // Training state codes reported by the port's state machine
    //------------------------------------------------------------------------
    typedef enum logic [3:0] {
        LTSSM_OTHER      = 4'h0,
        LTSSM_POLL_CFG   = 4'h1,
        LTSSM_POLL_CMPL  = 4'h2,
        LTSSM_RECOV_LOCK = 4'h3,
        LTSSM_RECOV_SPD  = 4'h4
    } ltssm_state_e;

    // Compliance tracking states
    typedef enum logic [0:0] {
        CMPL_IDLE   = 1'b0,
        CMPL_ACTIVE = 1'b1
    } cmpl_state_e;

endpackage

/* File: margin_level_if.sv */
// Carrier between the control block and the margin level decoder
`timescale 1ns/10ps
interface margin_level_if;
    import link_margin_pkg::*;

    logic [2:0] code;
    logic [9:0] full_mv;
    logic [9:0] low_mv;
    logic       reserved;
    logic       normal;

    modport decoder (input code, output full_mv, low_mv, reserved, normal);
    modport user    (output code, input full_mv, low_mv, reserved, normal);
endinterface

/* File: margin_level_decode.sv */
// Decoder from transmit swing code to margin voltages
`timescale 1ns/10ps
module margin_level_decode
    import link_margin_pkg::*;
(
    // Code in, voltages out
    margin_level_if.decoder m
);

    //------------------------------------------------------------------------
    // Voltage table
    //------------------------------------------------------------------------
    // Reserved codes give zero volts so nothing downstream drives them
    always_comb begin
        m.full_mv  = MV_NONE;
        m.low_mv   = MV_NONE;
        m.reserved = 1'b0;
        m.normal   = 1'b0;
        case (m.code)
            3'h0: begin
                m.normal = 1'b1;
            end
            3'h1: begin
                m.full_mv = MV_FULL_1;
                m.low_mv  = MV_LOW_1;
            end
            3'h2: begin
                m.full_mv = MV_FULL_2;
                m.low_mv  = MV_LOW_2;
            end
            3'h3: begin
                m.full_mv = MV_FULL_3;
                m.low_mv  = MV_LOW_3;
            end
            3'h4: begin
                m.full_mv = MV_FULL_4;
                m.low_mv  = MV_LOW_4;
            end
            3'h5: begin
                m.full_mv = MV_FULL_5;
                m.low_mv  = MV_LOW_5;
            end
            default: begin
                m.reserved = 1'b1;
            end
        endcase
    end

endmodule

/* File: link_compliance_margin_ctl.sv */
// Upper link control fields: transmit margin and compliance controls
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module link_compliance_margin_ctl
    import link_margin_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic        i_hot_reset,
    // Register port
    input  wire logic [11:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    // Training state machine and lower fields
    input  wire logic [3:0]  i_ltssm_state,
    input  wire logic        i_force_compliance_entry,
    input  wire logic        i_select_deemph,
    input  wire logic [7:0]  i_lane_drive_level,
    // Transmitter controls
    output logic      [2:0]  o_tx_swing_level,
    output logic      [9:0]  o_margin_full_mv,
    output logic      [9:0]  o_margin_low_mv,
    output logic             o_margin_reserved,
    output logic             o_use_lane_drive,
    output logic      [7:0]  o_lane_drive_level,
    // Compliance controls
    output logic             o_cmpl_active,
    output logic             o_cmpl_modified_pattern,
    output logic             o_cmpl_skip_insert,
    output logic             o_cmpl_deemph_3p5db
);

    //------------------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------------------
    logic [2:0]  tx_swing_level_reg;
    logic        modified_pattern_select_reg;
    logic        compliance_skip_insert_reg;
    logic        compliance_deemph_sel_reg;
    logic [2:0]  swing_applied_reg;
    logic [3:0]  ltssm_prev_reg;
    cmpl_state_e cmpl_state_reg;
    cmpl_state_e cmpl_state_next;
    logic        cmpl_modpat_reg;
    logic        cmpl_skip_reg;
    logic        cmpl_deemph_reg;
    logic [9:0]  full_mv_reg;
    logic [9:0]  low_mv_reg;
    logic        reserved_reg;
    logic        lane_sel_reg;
    logic [7:0]  lane_drive_reg;
    logic [15:0] rdata_reg;
    logic        ctl_hit;
    logic        stat_hit;
    logic        ctl_wr;
    logic        ltssm_changed;
    logic        enter_poll_cfg;
    logic        enter_poll_cmpl;
    logic        enter_margin_ok;
    logic        in_poll_cmpl;
    logic [15:0] ctl_view;
    logic [15:0] stat_view;

    margin_level_if mlvl ();

    //------------------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------------------
    // Anything other than the two registers reads as zero
    always_comb begin
        ctl_hit  = 1'b0;
        stat_hit = 1'b0;
        if (i_addr == LCTL2_OFFSET) begin
            ctl_hit = 1'b1;
        end else if (i_addr == MARGIN_STAT_OFFSET) begin
            stat_hit = 1'b1;
        end
    end

    assign ctl_wr = i_wr && ctl_hit;

    //------------------------------------------------------------------------
    // Training state edge detection
    //------------------------------------------------------------------------
    // Previous state, so that entries are seen once and not every cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ltssm_prev_reg <= LTSSM_OTHER;
        end else begin
            ltssm_prev_reg <= i_ltssm_state;
        end
    end

    assign ltssm_changed   = (i_ltssm_state != ltssm_prev_reg);
    assign in_poll_cmpl    = (i_ltssm_state == LTSSM_POLL_CMPL);
    assign enter_poll_cfg  = ltssm_changed &&
                             (i_ltssm_state == LTSSM_POLL_CFG);
    assign enter_poll_cmpl = ltssm_changed && in_poll_cmpl;
    assign enter_margin_ok = ltssm_changed &&
                             (i_ltssm_state == LTSSM_RECOV_LOCK);

    //------------------------------------------------------------------------
    // Transmit swing field
    //------------------------------------------------------------------------
    // The fundamental reset and entry into Polling.Configuration clear it; a hot reset leaves it alone.
    // A software write in the same cycle as the clear wins, since it is the
    // newer intent.
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            tx_swing_level_reg <= SWING_RESET;
        end else if (ctl_wr) begin
            tx_swing_level_reg <= i_wdata[SWING_MSB:SWING_LSB];
        end else if (enter_poll_cfg) begin
            tx_swing_level_reg <= SWING_NORMAL;
        end
    end

    //------------------------------------------------------------------------
    // Modified compliance select bit
    //------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            modified_pattern_select_reg <= BIT_RESET;
        end else if (ctl_wr) begin
            modified_pattern_select_reg <= i_wdata[MODPAT_BIT];
        end
    end

    //------------------------------------------------------------------------
    // Compliance skip insert bit
    //------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            compliance_skip_insert_reg <= BIT_RESET;
        end else if (ctl_wr) begin
            compliance_skip_insert_reg <= i_wdata[SKIP_BIT];
        end
    end

    //------------------------------------------------------------------------
    // Compliance de-emphasis select bit
    //------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            compliance_deemph_sel_reg <= DEEMPH_6DB;
        end else if (ctl_wr) begin
            compliance_deemph_sel_reg <= i_wdata[DEEMPH_BIT];
        end
    end

    //------------------------------------------------------------------------
    // Applied swing
    //------------------------------------------------------------------------
    // The line keeps its old level until the link passes a state where a
    // margin change is allowed; changing mid-stream would upset the partner.
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            swing_applied_reg <= SWING_RESET;
        end else if (enter_margin_ok) begin
            swing_applied_reg <= tx_swing_level_reg;
        end
    end

    //------------------------------------------------------------------------
    // Margin decoder
    //------------------------------------------------------------------------
    assign mlvl.code = swing_applied_reg;

    margin_level_decode u_decode (
        .m (mlvl.decoder)
    );

    //------------------------------------------------------------------------
    // Registered transmitter outputs
    //------------------------------------------------------------------------
    // Lane registers take over only at the normal code
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            full_mv_reg    <= MV_NONE;
            low_mv_reg     <= MV_NONE;
            reserved_reg   <= 1'b0;
            lane_sel_reg   <= 1'b1;
            lane_drive_reg <= LANE_DRV_RESET;
        end else begin
            full_mv_reg    <= mlvl.full_mv;
            low_mv_reg     <= mlvl.low_mv;
            reserved_reg   <= mlvl.reserved;
            lane_sel_reg   <= mlvl.normal;
            lane_drive_reg <= mlvl.normal ? i_lane_drive_level
                                          : LANE_DRV_RESET;
        end
    end

    //------------------------------------------------------------------------
    // Compliance tracking state machine
    //------------------------------------------------------------------------
    // Active from entry into Polling.Compliance until the state is left or
    // a hot reset takes the link down
    always_comb begin
        cmpl_state_next = cmpl_state_reg;
        case (cmpl_state_reg)
            CMPL_IDLE: begin
                if (enter_poll_cmpl && !i_hot_reset) begin
                    cmpl_state_next = CMPL_ACTIVE;
                end
            end
            CMPL_ACTIVE: begin
                if (!in_poll_cmpl || i_hot_reset) begin
                    cmpl_state_next = CMPL_IDLE;
                end
            end
            default: begin
                cmpl_state_next = CMPL_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            cmpl_state_reg <= CMPL_IDLE;
        end else begin
            cmpl_state_reg <= cmpl_state_next;
        end
    end

    //------------------------------------------------------------------------
    // Compliance settings caught at entry
    //------------------------------------------------------------------------
    // Caught once so a write during compliance cannot change the pattern
    // under way; the next entry picks up new values.
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            cmpl_modpat_reg <= BIT_RESET;
            cmpl_skip_reg   <= BIT_RESET;
            cmpl_deemph_reg <= DEEMPH_6DB;
        end else if (enter_poll_cmpl && !i_hot_reset) begin
            cmpl_modpat_reg <= modified_pattern_select_reg;
            cmpl_skip_reg   <= compliance_skip_insert_reg;
            if (i_force_compliance_entry) begin
                cmpl_deemph_reg <= compliance_deemph_sel_reg;
            end else begin
                cmpl_deemph_reg <= i_select_deemph;
            end
        end
    end

    //------------------------------------------------------------------------
    // Read views
    //------------------------------------------------------------------------
    // Bits outside the four control fields and the seven status fields read as zero
    always_comb begin
        ctl_view                        = RDATA_ZERO;
        ctl_view[SWING_MSB:SWING_LSB]   = tx_swing_level_reg;
        ctl_view[MODPAT_BIT]            = modified_pattern_select_reg;
        ctl_view[SKIP_BIT]              = compliance_skip_insert_reg;
        ctl_view[DEEMPH_BIT]            = compliance_deemph_sel_reg;
        stat_view                       = RDATA_ZERO;
        stat_view[STAT_SWING_MSB:STAT_SWING_LSB] = swing_applied_reg;
        stat_view[STAT_LANE_BIT]        = lane_sel_reg;
        stat_view[STAT_RSVD_BIT]        = reserved_reg;
        stat_view[STAT_CMPL_BIT]        = (cmpl_state_reg == CMPL_ACTIVE);
        stat_view[STAT_MODP_BIT]        = cmpl_modpat_reg;
        stat_view[STAT_SKIP_BIT]        = cmpl_skip_reg;
        stat_view[STAT_DEEM_BIT]        = cmpl_deemph_reg;
    end

    //------------------------------------------------------------------------
    // Read data register
    //------------------------------------------------------------------------
    // Data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            rdata_reg <= RDATA_ZERO;
        end else if (i_rd && ctl_hit) begin
            rdata_reg <= ctl_view;
        end else if (i_rd && stat_hit) begin
            rdata_reg <= stat_view;
        end else begin
            rdata_reg <= RDATA_ZERO;
        end
    end

    //------------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------------
    assign o_rdata                 = rdata_reg;
    assign o_tx_swing_level        = swing_applied_reg;
    assign o_margin_full_mv        = full_mv_reg;
    assign o_margin_low_mv         = low_mv_reg;
    assign o_margin_reserved       = reserved_reg;
    assign o_use_lane_drive        = lane_sel_reg;
    assign o_lane_drive_level      = lane_drive_reg;
    assign o_cmpl_active           = (cmpl_state_reg == CMPL_ACTIVE);
    // Pattern controls only mean anything while compliance runs
    assign o_cmpl_modified_pattern = o_cmpl_active && cmpl_modpat_reg;
    assign o_cmpl_skip_insert      = o_cmpl_active && cmpl_skip_reg;
    assign o_cmpl_deemph_3p5db     = o_cmpl_active && cmpl_deemph_reg;

endmodule

/* File: link_margin_checker.sv */
// Port-level assertions for the link compliance margin block
`timescale 1ns/10ps
module link_margin_checker
    import link_margin_pkg::*;
(
    // Clock and resets
    input wire logic        i_clk_sys,
    input wire logic        i_reset_n,
    input wire logic        i_hot_reset,
    // Register port
    input wire logic [11:0] i_addr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    // Training state and transmitter outputs
    input wire logic [3:0]  i_ltssm_state,
    input wire logic [2:0]  o_tx_swing_level,
    input wire logic [9:0]  o_margin_full_mv,
    input wire logic [9:0]  o_margin_low_mv,
    input wire logic        o_margin_reserved,
    input wire logic        o_use_lane_drive,
    // Compliance outputs
    input wire logic        o_cmpl_active,
    input wire logic        o_cmpl_modified_pattern,
    input wire logic        o_cmpl_skip_insert,
    input wire logic        o_cmpl_deemph_3p5db
);
    //------------------------------------------------------------------------
    // Single clock domain
    //------------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    // Entry into Polling.Compliance, not blocked by hot reset
    sequence s_enter_cmpl;
        i_ltssm_state == 4'h2 && $past(i_ltssm_state) != 4'h2 && !i_hot_reset;
    endsequence

    //------------------------------------------------------------------------
    // Properties
    //------------------------------------------------------------------------
    property p_rd_idle;
        !i_rd |=> o_rdata == RDATA_ZERO;
    endproperty
    property p_rsvd_rd;
        i_rd && i_addr == LCTL2_OFFSET |=> o_rdata[15:13] == 3'h0;
    endproperty
    // Swing may only move on a lock entry, never on a plain write
    property p_swing_hold;
        !(i_ltssm_state == 4'h3 && $past(i_ltssm_state) != 4'h3)
            |=> $stable(o_tx_swing_level);
    endproperty
    property p_mv_code1;
        o_tx_swing_level == 3'h1
            |=> o_margin_full_mv == 10'd900 && o_margin_low_mv == 10'd500;
    endproperty
    property p_rsvd_code;
        1'b1 |=> o_margin_reserved == ($past(o_tx_swing_level) >= 3'h6);
    endproperty
    property p_lane_sel;
        1'b1 |=> o_use_lane_drive == ($past(o_tx_swing_level) == 3'h0);
    endproperty
    property p_cmpl_enter;
        s_enter_cmpl |=> o_cmpl_active;
    endproperty
    property p_cmpl_drop;
        i_ltssm_state != 4'h2 || i_hot_reset |=> !o_cmpl_active;
    endproperty
    property p_cmpl_gate;
        !o_cmpl_active |-> !(o_cmpl_modified_pattern || o_cmpl_skip_insert
                             || o_cmpl_deemph_3p5db);
    endproperty
    // Caught modified-pattern and de-emphasis settings must not follow later writes
    property p_cmpl_hold;
        o_cmpl_active ##1 o_cmpl_active |-> $stable(o_cmpl_deemph_3p5db)
            && $stable(o_cmpl_modified_pattern);
    endproperty

    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    a_rsvd_rd: assert property (p_rsvd_rd)
        else $error("reserved bits read nonzero");
    a_swing_hold: assert property (p_swing_hold)
        else $error("swing moved without lock entry");
    a_mv_code1: assert property (p_mv_code1)
        else $error("code 1 voltages wrong");
    a_rsvd_code: assert property (p_rsvd_code)
        else $error("reserved flag wrong");
    a_lane_sel: assert property (p_lane_sel)
        else $error("lane select wrong");
    a_cmpl_enter: assert property (p_cmpl_enter)
        else $error("compliance entry missed");
    a_cmpl_drop: assert property (p_cmpl_drop)
        else $error("compliance not dropped");
    a_cmpl_gate: assert property (p_cmpl_gate)
        else $error("controls high while idle");
    a_cmpl_hold: assert property (p_cmpl_hold)
        else $error("caught settings moved");
endmodule

bind link_compliance_margin_ctl
    link_margin_checker u_link_margin_checker (.*);

/* File: link_compliance_margin_ctl_tb.sv */
// Self-checking testbench for the link compliance margin block
`timescale 1ns/10ps
module link_compliance_margin_ctl_tb;
    import link_margin_pkg::*;

    typedef struct packed {
        logic [2:0] code;
        logic [9:0] full;
        logic [9:0] low;
        logic       rsvd;
    } row_s;

    logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_hot_reset = 1'b0;
    logic i_wr = 1'b0, i_rd = 1'b0, i_force_compliance_entry = 1'b0;
    logic i_select_deemph = 1'b0, o_margin_reserved, o_use_lane_drive;
    logic o_cmpl_active, o_cmpl_modified_pattern, o_cmpl_skip_insert;
    logic o_cmpl_deemph_3p5db;
    logic [11:0] i_addr = 12'h000;
    logic [15:0] i_wdata = 16'h0000, o_rdata, rd_val;
    logic [3:0]  i_ltssm_state = 4'h0;
    logic [7:0]  i_lane_drive_level = 8'hA5, o_lane_drive_level;
    logic [2:0]  o_tx_swing_level, prev = 3'h0;
    logic [9:0]  o_margin_full_mv, o_margin_low_mv;
    int          num_errors = 0, checked = 0, cycles = 0;
    // Codes 1..7 first so code 0 proves the old value is held until lock
    row_s rows [8] = '{'{3'h1, 10'd900, 10'd500, 1'b0},
        '{3'h2, 10'd700, 10'd400, 1'b0}, '{3'h3, 10'd500, 10'd300, 1'b0},
        '{3'h4, 10'd300, 10'd200, 1'b0}, '{3'h5, 10'd200, 10'd100, 1'b0},
        '{3'h6, 10'd0, 10'd0, 1'b1}, '{3'h7, 10'd0, 10'd0, 1'b1},
        '{3'h0, 10'd0, 10'd0, 1'b0}};

    logic [3:0]  cmpl_v;
    assign cmpl_v = {o_cmpl_active, o_cmpl_modified_pattern,
                     o_cmpl_skip_insert, o_cmpl_deemph_3p5db};

    link_compliance_margin_ctl u_link_compliance_margin_ctl (.*);

    //------------------------------------------------------------------------
    // Clock, hang limit and shared tasks
    //------------------------------------------------------------------------
    always #5 i_clk_sys = ~i_clk_sys;

    // Run takes under two hundred cycles; 3000 means a hang
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        rd_val = o_rdata;
    endtask

    // Applied outputs land two edges after entry
    task automatic go(input logic [3:0] s);
        @(posedge i_clk_sys);
        i_ltssm_state <= s;
        repeat (2) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic end_of_test;
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    //------------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        @(posedge i_clk_sys);
        #1;
        chk(16'(o_use_lane_drive), 16'h0001);
        rd(LCTL2_OFFSET);
        chk(rd_val, 16'h0000);
        // Every swing code: held through Recovery.Speed, applied at lock
        for (int k = 0; k < 8; k++) begin
            wr(LCTL2_OFFSET, {6'h00, rows[k].code, 7'h00});
            rd(LCTL2_OFFSET);
            chk(rd_val, {6'h00, rows[k].code, 7'h00});
            go(4'h4);
            chk(16'(o_tx_swing_level), 16'(prev));
            go(4'h3);
            chk(16'(o_tx_swing_level), 16'(rows[k].code));
            chk(16'(o_margin_reserved), 16'(rows[k].rsvd));
            chk(16'(o_use_lane_drive), 16'(rows[k].code == 3'h0));
            chk(16'(o_lane_drive_level),
                (rows[k].code == 3'h0) ? 16'h00A5 : 16'h0000);
            if (!rows[k].rsvd && rows[k].code != 3'h0) begin
                chk(16'(o_margin_full_mv), 16'(rows[k].full));
                chk(16'(o_margin_low_mv), 16'(rows[k].low));
            end
            go(4'h0);
            prev = rows[k].code;
        end
        // Reserved bits, unmapped and status writes are all dropped
        wr(LCTL2_OFFSET, 16'hFFFF);
        wr(12'h072, 16'h0000);
        wr(MARGIN_STAT_OFFSET, 16'h0000);
        rd(LCTL2_OFFSET);
        chk(rd_val, 16'h1F80);
        rd(12'h072);
        chk(rd_val, 16'h0000);
        go(4'h1);
        rd(LCTL2_OFFSET);
        chk(rd_val, 16'h1C00);
        // Forced compliance catches the bits, hot reset drops only state
        @(posedge i_clk_sys) i_force_compliance_entry <= 1'b1;
        go(4'h2);
        chk(16'(cmpl_v), 16'h000F);
        rd(MARGIN_STAT_OFFSET);
        chk(rd_val, 16'h01E8);
        @(posedge i_clk_sys) i_hot_reset <= 1'b1;
        @(posedge i_clk_sys);
        i_hot_reset <= 1'b0;
        @(posedge i_clk_sys);
        #1;
        chk(16'(o_cmpl_active), 16'h0000);
        rd(LCTL2_OFFSET);
        chk(rd_val, 16'h1C00);
        go(4'h0);
        wr(LCTL2_OFFSET, 16'h0C00);
        go(4'h2);
        chk(16'(cmpl_v), 16'h000E);
        go(4'h0);
        // Not forced: de-emphasis follows the selectable input
        wr(LCTL2_OFFSET, 16'h1C00);
        i_force_compliance_entry <= 1'b0;
        i_select_deemph <= 1'b1;
        go(4'h2);
        chk(16'(o_cmpl_deemph_3p5db), 16'h0001);
        go(4'h0);
        @(posedge i_clk_sys) i_select_deemph <= 1'b0;
        go(4'h2);
        chk(16'(cmpl_v), 16'h000E);
        go(4'h0);
        // Mid-run reset clears the fields again
        @(posedge i_clk_sys) i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        rd(LCTL2_OFFSET);
        chk(rd_val, 16'h0000);
        chk(16'(o_use_lane_drive), 16'h0001);
        end_of_test();
    end
endmodule
